// File: verif/lfdl_checker.sv
// Assertions on the register port that joins the host controller and the device.
// Assumes the bench wires it to the interface signals; one clock domain.
`timescale 1ns/1ps
module lfdl_checker (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Register port signals.
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic int_n
);
  import lfdl_pkg::*;
  // Shadows of what the host wrote; the registers reset to zero as well.
  logic [7:0] mask_r, ma_r, mb_r, tx_r, seen_r, seen_nxt, hit;
  logic st_rd_r;
  logic st_wr;
  logic mapped;
  assign st_wr = wr && addr == LFDL_STATUS_ADDR;
  assign mapped = addr[7:2] == 6'h30 || (addr >= 8'h20 && addr <= 8'h24);
  // Flags once read as set must stay set until a one is written over them.
  assign seen_nxt = (seen_r | (st_rd_r ? rdata & LFDL_STATUS_MASK : 8'h00))
    & ~(st_wr ? wdata : 8'h00);
  // Unmasked flags in a status answer; no clear can land in that cycle.
  assign hit = st_rd_r ? rdata & mask_r : 8'h00;
  // Shadow registers follow writes only, so a stuck design register shows up.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {mask_r, ma_r, mb_r, tx_r, seen_r} <= '0;
      st_rd_r <= 1'b0;
    end else begin
      if (wr && addr == LFDL_MASK_ADDR) mask_r <= wdata;
      if (wr && addr == LFDL_MATCH_A_ADDR) ma_r <= wdata;
      if (wr && addr == LFDL_MATCH_B_ADDR) mb_r <= wdata;
      if (wr && addr == LFDL_TX_BYTE_ADDR) tx_r <= wdata;
      seen_r <= seen_nxt;
      st_rd_r <= rd && addr == LFDL_STATUS_ADDR;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  one_strobe_a: assert property (!(wr && rd)) else $error("write and read together");
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00) else $error("stray read data");
  unmapped_zero_a: assert property (rd && !mapped |=> rdata == 8'h00) else $error("unmapped read");
  match_a_echo_a: assert property (rd && addr == LFDL_MATCH_A_ADDR |=> rdata == ma_r)
    else $error("match a readback");
  match_b_echo_a: assert property (rd && addr == LFDL_MATCH_B_ADDR |=> rdata == mb_r)
    else $error("match b readback");
  tx_echo_a: assert property (rd && addr == LFDL_TX_BYTE_ADDR |=> rdata == tx_r)
    else $error("tx byte readback");
  status_keep_a: assert property (st_rd_r |-> (rdata & seen_r) == seen_r)
    else $error("status flag lost");
  match_int_a: assert property (hit[LFDL_ST_MATCH] |-> !int_n) else $error("no match int");
  empty_int_a: assert property (hit[LFDL_ST_TX_EMPTY] |-> !int_n) else $error("no empty int");
  full_int_a: assert property (hit[LFDL_ST_RX_FULL] |-> !int_n) else $error("no full int");
  mask_off_a: assert property ((mask_r & LFDL_STATUS_MASK) == 8'h00 |-> int_n)
    else $error("interrupt while masked");
endmodule : lfdl_checker

// File: verif/tb_top.sv
// Bench joining the host controller and the link byte device through their interface.
// Assumes a 100 MHz core_clk; drives the software port and both bit streams.
`timescale 1ns/1ps
module tb_top;
  import lfdl_pkg::*;
  // Clock, reset and software port.
  logic core_clk, reset_n, sw_wr, sw_rd, irq;
  logic [2:0] sw_addr;
  logic [7:0] sw_wdata, sw_rdata;
  // Framer bit streams.
  logic rx_bit, rx_bit_stb, tx_slot_stb, mf_boundary, d4_mode, tx_ext_frame_bit, tx_bit;
  int failures;
  int compares;
  lfdl_if bus_if ();
  lfdl_host u_lfdl_host (.core_clk(core_clk), .reset_n(reset_n), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq),
    .bus(bus_if));
  lfdl_device u_lfdl_device (.core_clk(core_clk), .reset_n(reset_n), .bus(bus_if),
    .rx_bit(rx_bit), .rx_bit_stb(rx_bit_stb), .tx_slot_stb(tx_slot_stb),
    .mf_boundary(mf_boundary), .d4_mode(d4_mode), .tx_ext_frame_bit(tx_ext_frame_bit),
    .tx_bit(tx_bit));
  lfdl_checker u_lfdl_checker (.core_clk(core_clk), .reset_n(reset_n), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
    .int_n(bus_if.int_n));
  // Compares one value and reports a difference at once.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out;
    $display("Counts: compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  // One-cycle software write strobe.
  task automatic sw_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge core_clk);
    sw_wr <= 1'b0;
  endtask : sw_write
  // One-cycle software read; data stand in the following cycle only.
  task automatic sw_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask : sw_read
  // Polls the done flag with a bound, then clears it; a hang ends the run.
  task automatic wait_done;
    logic [7:0] s;
    s = 8'h00;
    for (int n = 0; n < 20 && !s[LFDLH_ST_DONE]; n++) sw_read(LFDLH_STATUS_ADDR, s);
    if (s[LFDLH_ST_DONE] !== 1'b1) begin
      failures++;
      $display("MISMATCH host done expected 1 seen %b", s[LFDLH_ST_DONE]);
      close_out();
    end
    sw_write(LFDLH_STATUS_ADDR, 8'h01);
  endtask : wait_done
  // Device register write and read carried out by the host controller.
  task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
    sw_write(LFDLH_ADDR_ADDR, a);
    sw_write(LFDLH_WDATA_ADDR, d);
    sw_write(LFDLH_GO_ADDR, 8'h01);
    wait_done();
  endtask : dev_wr
  task automatic dev_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    sw_write(LFDLH_ADDR_ADDR, a);
    sw_write(LFDLH_GO_ADDR, 8'h02);
    wait_done();
    sw_read(LFDLH_RESULT_ADDR, d);
    chk(what, exp, d);
  endtask : dev_chk
  // Sends n received link bits, element 0 first.
  task automatic rx_bits(input logic [16:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      rx_bit <= v[i];
      rx_bit_stb <= 1'b1;
      @(posedge core_clk);
      rx_bit_stb <= 1'b0;
    end
  endtask : rx_bits
  // Offers n outgoing slots; the boundary mark goes with the first only.
  task automatic tx_bits(input logic [8:0] exp, input int n, input logic mf);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      tx_slot_stb <= 1'b1;
      mf_boundary <= mf && i == 0;
      @(posedge core_clk);
      tx_slot_stb <= 1'b0;
      #1;
      chk("tx bit", {7'h00, exp[i]}, {7'h00, tx_bit});
    end
  endtask : tx_bits
  // Reset values, read-back, the read-only byte and an unmapped place.
  task automatic test_regs;
    for (logic [7:0] a = 8'hc0; a < 8'hc4; a++) dev_chk("reset value", a, 8'h00);
    dev_wr(LFDL_RX_BYTE_ADDR, 8'h5a);
    dev_wr(LFDL_MATCH_A_ADDR, 8'ha5);
    dev_wr(LFDL_MATCH_B_ADDR, 8'h3c);
    dev_wr(LFDL_TX_BYTE_ADDR, 8'h4b);
    dev_chk("read only byte", LFDL_RX_BYTE_ADDR, 8'h00);
    dev_chk("match a", LFDL_MATCH_A_ADDR, 8'ha5);
    dev_chk("match b", LFDL_MATCH_B_ADDR, 8'h3c);
    dev_chk("tx byte", LFDL_TX_BYTE_ADDR, 8'h4b);
    dev_chk("unmapped", 8'h30, 8'h00);
    $display("test_regs done");
  endtask : test_regs
  // Byte assembly, full and match flags, both interrupt paths, sticky flags.
  task automatic test_rx;
    sw_write(LFDLH_MASK_ADDR, 8'h02);
    dev_wr(LFDL_MASK_ADDR, 8'h0a);
    rx_bits(17'h0_00a5, 8);
    dev_chk("rx byte", LFDL_RX_BYTE_ADDR, 8'ha5);
    dev_chk("status", LFDL_STATUS_ADDR, 8'h0a);
    chk("int_n", 8'h00, {7'h00, bus_if.int_n});
    chk("irq", 8'h01, {7'h00, irq});
    dev_chk("status kept", LFDL_STATUS_ADDR, 8'h0a);
    dev_wr(LFDL_STATUS_ADDR, 8'h0a);
    chk("int_n cleared", 8'h01, {7'h00, bus_if.int_n});
    rx_bits(17'h0_003c, 8);
    dev_chk("match b status", LFDL_STATUS_ADDR, 8'h0a);
    dev_wr(LFDL_STATUS_ADDR, 8'h0a);
    sw_write(LFDLH_STATUS_ADDR, 8'h02);
    $display("test_rx done");
  endtask : test_rx
  // Zero after exactly five ones dropped, zero after six ones kept.
  task automatic test_destuff;
    dev_wr(LFDL_RX_CTRL2_ADDR, 8'h08);
    chk("irq cleared", 8'h00, {7'h00, irq});
    rx_bits(17'h0_019f, 9);
    dev_chk("destuffed", LFDL_RX_BYTE_ADDR, 8'hdf);
    dev_chk("no match", LFDL_STATUS_ADDR, 8'h08);
    rx_bits(17'h0_000f, 8);
    dev_chk("six ones", LFDL_RX_BYTE_ADDR, 8'h0f);
    dev_wr(LFDL_STATUS_ADDR, 8'h08);
    $display("test_destuff done");
  endtask : test_destuff
  // Serial order, empty flag and interrupt, repeat of an unrefreshed byte, stuffing.
  task automatic test_tx;
    dev_wr(LFDL_MASK_ADDR, 8'h04);
    tx_bits(9'h04b, 8, 1'b0);
    dev_chk("empty flag", LFDL_STATUS_ADDR, 8'h04);
    chk("empty int_n", 8'h00, {7'h00, bus_if.int_n});
    dev_wr(LFDL_STATUS_ADDR, 8'h04);
    tx_bits(9'h04b, 8, 1'b0);
    dev_wr(LFDL_TX_CTRL2_ADDR, 8'h20);
    dev_wr(LFDL_TX_BYTE_ADDR, 8'hff);
    tx_bits(9'h1df, 9, 1'b0);
    $display("test_tx done");
  endtask : test_tx
  // Masked flag, multiframe loading of the frame pattern, external frame bits.
  task automatic test_d4;
    dev_wr(LFDL_MASK_ADDR, 8'h00);
    chk("masked int_n", 8'h01, {7'h00, bus_if.int_n});
    dev_wr(LFDL_TX_CTRL2_ADDR, 8'h40);
    dev_wr(LFDL_TX_BYTE_ADDR, 8'h1c);
    @(posedge core_clk);
    d4_mode <= 1'b1;
    tx_bits(9'h0ff, 8, 1'b0);
    tx_bits(9'h01c, 8, 1'b1);
    dev_wr(LFDL_TX_CTRL1_ADDR, 8'h04);
    tx_ext_frame_bit <= 1'b1;
    tx_bits(9'h0ff, 8, 1'b1);
    $display("test_d4 done");
  endtask : test_d4
  // Free-running clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Reset for 20 cycles, then the scenarios in turn.
  initial begin
    reset_n = 1'b0;
    {sw_addr, sw_wdata, sw_wr, sw_rd} = '0;
    {rx_bit, rx_bit_stb, tx_slot_stb, mf_boundary, d4_mode, tx_ext_frame_bit} = '0;
    failures = 0;
    compares = 0;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    test_regs();
    test_rx();
    test_destuff();
    test_tx();
    test_d4();
    close_out();
  end
endmodule : tb_top

// File: verilog/lfdl_device.sv
// Legacy byte port to the T1 data link or signaling frame bits.
// Assumes the framer gives one strobe per link bit position on core_clk.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module lfdl_device (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Register port to the host.
  lfdl_if.device bus,
  // Receive bit stream from the framer.
  input wire logic rx_bit,
  input wire logic rx_bit_stb,
  // Transmit bit stream to the framer.
  input wire logic tx_slot_stb,
  input wire logic mf_boundary,
  input wire logic d4_mode,
  input wire logic tx_ext_frame_bit,
  output logic tx_bit
);
  import lfdl_pkg::*;

  // Host-visible registers.
  logic [7:0] rx_byte_r;
  logic [7:0] tx_byte_r;
  logic [7:0] match_a_r;
  logic [7:0] match_b_r;
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] mask_r;
  logic [7:0] rx_ctrl2_r;
  logic [7:0] tx_ctrl1_r;
  logic [7:0] tx_ctrl2_r;
  logic [7:0] rdata_r;
  // Receive datapath state.
  logic [7:0] rx_shift_r;
  logic [2:0] rx_cnt_r;
  logic [2:0] rx_ones_r;
  // Transmit datapath state.
  logic [7:0] tx_shift_r;
  logic [7:0] tx_hold_r;
  logic [2:0] tx_cnt_r;
  logic [2:0] tx_ones_r;
  logic tx_bit_r;

  // Address decode of the register port.
  wire sel_rx = bus.addr == LFDL_RX_BYTE_ADDR;
  wire sel_tx = bus.addr == LFDL_TX_BYTE_ADDR;
  wire sel_ma = bus.addr == LFDL_MATCH_A_ADDR;
  wire sel_mb = bus.addr == LFDL_MATCH_B_ADDR;
  wire sel_st = bus.addr == LFDL_STATUS_ADDR;
  wire sel_mk = bus.addr == LFDL_MASK_ADDR;
  wire sel_rc2 = bus.addr == LFDL_RX_CTRL2_ADDR;
  wire sel_tc1 = bus.addr == LFDL_TX_CTRL1_ADDR;
  wire sel_tc2 = bus.addr == LFDL_TX_CTRL2_ADDR;

  // Read multiplexer; unmapped addresses read as zero.
  wire [7:0] rd_mux = sel_rx ? rx_byte_r :
                      sel_tx ? tx_byte_r :
                      sel_ma ? match_a_r :
                      sel_mb ? match_b_r :
                      sel_st ? status_r :
                      sel_mk ? mask_r :
                      sel_rc2 ? rx_ctrl2_r :
                      sel_tc1 ? tx_ctrl1_r :
                      sel_tc2 ? tx_ctrl2_r : 8'h00;

  // Receive: a zero right after exactly five ones is a stuffed bit.
  wire destuff_en = rx_ctrl2_r[LFDL_RX_DESTUFF_BIT];
  wire rx_drop = destuff_en && !rx_bit && (rx_ones_r == LFDL_STUFF_RUN);
  wire rx_take = rx_bit_stb && !rx_drop;
  // The new bit enters at the top so the first bit lands in bit 0.
  wire [7:0] rx_next_shift = {rx_bit, rx_shift_r[7:1]};
  wire rx_done = rx_take && (rx_cnt_r == LFDL_LAST_BIT);
  wire rx_match = (rx_next_shift == match_a_r) || (rx_next_shift == match_b_r);

  // Transmit: a stuffed zero goes out in place of the next data bit.
  wire stuff_en = tx_ctrl2_r[LFDL_TX_STUFF_BIT];
  wire tx_stuff = stuff_en && (tx_ones_r == LFDL_STUFF_RUN);
  wire tx_adv = tx_slot_stb && !tx_stuff;
  wire tx_need_load = tx_cnt_r == 3'h0;
  // With multiframe loading only a boundary picks up a fresh byte.
  wire mf_only = tx_ctrl2_r[LFDL_TX_MF_LOAD_BIT];
  wire load_new = !mf_only || mf_boundary;
  // Without a fresh load the last byte is repeated.
  wire [7:0] tx_src = !tx_need_load ? tx_shift_r :
                      load_new ? tx_byte_r : tx_hold_r;
  // External signaling bits apply only in D4 with control bit 2 set.
  wire use_ext = d4_mode && tx_ctrl1_r[LFDL_TX_EXT_FRAME_BIT];
  wire tx_data_bit = use_ext ? tx_ext_frame_bit : tx_src[0];
  wire tx_out = tx_stuff ? 1'b0 : tx_data_bit;
  wire tx_done = tx_adv && (tx_cnt_r == LFDL_LAST_BIT);

  // Status events; a set in the same cycle as a clear wins.
  wire [7:0] st_set = {4'h0, rx_done, tx_done, rx_done && rx_match, 1'b0};
  wire [7:0] st_clr = (bus.wr && sel_st) ? bus.wdata : 8'h00;
  assign status_nxt = ((status_r & ~st_clr) | st_set) & LFDL_STATUS_MASK;

  // Interrupt is low while any unmasked status bit is set.
  assign bus.int_n = ~|(status_r & mask_r);
  assign bus.rdata = rdata_r;
  assign tx_bit = tx_bit_r;

  // Status and read data register.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= LFDL_BYTE_RESET;
      rdata_r <= LFDL_BYTE_RESET;
    end else begin
      status_r <= status_nxt;
      // Read data stand only in the cycle after the read.
      rdata_r <= bus.rd ? rd_mux : 8'h00;
    end
  end

  // Writable configuration registers.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_byte_r <= LFDL_BYTE_RESET;
      match_a_r <= LFDL_BYTE_RESET;
      match_b_r <= LFDL_BYTE_RESET;
      mask_r <= LFDL_BYTE_RESET;
      rx_ctrl2_r <= LFDL_BYTE_RESET;
      tx_ctrl1_r <= LFDL_BYTE_RESET;
      tx_ctrl2_r <= LFDL_BYTE_RESET;
    end else if (bus.wr) begin
      // Only the addressed register takes the write data.
      if (sel_tx) begin
        tx_byte_r <= bus.wdata;
      end
      if (sel_ma) begin
        match_a_r <= bus.wdata;
      end
      if (sel_mb) begin
        match_b_r <= bus.wdata;
      end
      if (sel_mk) begin
        mask_r <= bus.wdata & LFDL_STATUS_MASK;
      end
      if (sel_rc2) begin
        rx_ctrl2_r <= bus.wdata;
      end
      if (sel_tc1) begin
        tx_ctrl1_r <= bus.wdata;
      end
      if (sel_tc2) begin
        tx_ctrl2_r <= bus.wdata;
      end
    end
  end

  // Receive run counter; it saturates so long runs never look like five.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_ones_r <= 3'h0;
    end else if (rx_bit_stb) begin
      if (!rx_bit) begin
        rx_ones_r <= 3'h0;
      end else if (rx_ones_r != LFDL_RUN_SAT) begin
        rx_ones_r <= rx_ones_r + 3'h1;
      end
    end
  end

  // Receive assembly; the byte is overwritten every eight bits.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_shift_r <= LFDL_BYTE_RESET;
      rx_cnt_r <= 3'h0;
      rx_byte_r <= LFDL_BYTE_RESET;
    end else if (rx_take) begin
      rx_shift_r <= rx_next_shift;
      rx_cnt_r <= rx_cnt_r + 3'h1;
      // A host that is late loses the previous byte here.
      if (rx_done) begin
        rx_byte_r <= rx_next_shift;
      end
    end
  end

  // Transmit run counter counts ones actually sent on the link.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_ones_r <= 3'h0;
    end else if (tx_slot_stb) begin
      if (!tx_out) begin
        tx_ones_r <= 3'h0;
      end else if (tx_ones_r != LFDL_RUN_SAT) begin
        tx_ones_r <= tx_ones_r + 3'h1;
      end
    end
  end

  // Transmit serialiser; a stuffed zero holds the data bit back a slot.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_shift_r <= LFDL_BYTE_RESET;
      tx_hold_r <= LFDL_BYTE_RESET;
      tx_cnt_r <= 3'h0;
      tx_bit_r <= 1'b0;
    end else if (tx_slot_stb) begin
      tx_bit_r <= tx_out;
      if (tx_adv) begin
        tx_shift_r <= {1'b0, tx_src[7:1]};
        tx_cnt_r <= tx_cnt_r + 3'h1;
        // The hold copy keeps the byte to repeat between boundaries.
        if (tx_need_load) begin
          tx_hold_r <= tx_src;
        end
      end
    end
  end
endmodule : lfdl_device

// File: verilog/lfdl_host.sv
// Host-side controller that performs register accesses on the device.
// Assumes software drives the user port with one-cycle strobes.
`timescale 1ns/1ps
module lfdl_host (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Software register port.
  input wire logic [2:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  output logic irq,
  // Device register port.
  lfdl_if.host bus
);
  import lfdl_pkg::*;

  // Own registers and access sequencer.
  lfdlh_state_type state_r;
  lfdlh_state_type state_nxt;
  logic [7:0] tgt_addr_r;
  logic [7:0] tgt_wdata_r;
  logic [7:0] result_r;
  logic [1:0] status_r;
  logic [1:0] mask_r;
  logic [7:0] sw_rdata_r;
  logic op_rd_r;
  logic int_n_d_r;

  // Decode of the software port.
  wire go = sw_wr && (sw_addr == LFDLH_GO_ADDR) && (state_r == LFDLH_IDLE);
  wire go_any = go && (sw_wdata[LFDLH_GO_WRITE] || sw_wdata[LFDLH_GO_READ]);
  wire in_issue = state_r == LFDLH_ISSUE;
  wire done_ev = (in_issue && !op_rd_r) || (state_r == LFDLH_CAPTURE);
  // Device interrupt is caught on its falling edge; sources are same-clock logic.
  wire dev_int_ev = int_n_d_r && !bus.int_n;
  wire [1:0] st_clr = (sw_wr && sw_addr == LFDLH_STATUS_ADDR) ? sw_wdata[1:0] : 2'h0;
  wire [7:0] rd_mux = (sw_addr == LFDLH_ADDR_ADDR) ? tgt_addr_r :
                      (sw_addr == LFDLH_WDATA_ADDR) ? tgt_wdata_r :
                      (sw_addr == LFDLH_RESULT_ADDR) ? result_r :
                      (sw_addr == LFDLH_STATUS_ADDR) ? {6'h00, status_r} :
                      (sw_addr == LFDLH_MASK_ADDR) ? {6'h00, mask_r} : 8'h00;

  // One access per go; a busy controller ignores further go writes.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LFDLH_IDLE: state_nxt = go_any ? LFDLH_ISSUE : LFDLH_IDLE;
      LFDLH_ISSUE: state_nxt = op_rd_r ? LFDLH_CAPTURE : LFDLH_IDLE;
      LFDLH_CAPTURE: state_nxt = LFDLH_IDLE;
      default: state_nxt = LFDLH_IDLE;
    endcase
  end

  // Device strobes come straight from the sequencer state.
  assign bus.addr = tgt_addr_r;
  assign bus.wdata = tgt_wdata_r;
  assign bus.wr = in_issue && !op_rd_r;
  assign bus.rd = in_issue && op_rd_r;
  assign sw_rdata = sw_rdata_r;
  assign irq = |(status_r & mask_r);

  // Sequencer and captured read result.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= LFDLH_IDLE;
      op_rd_r <= 1'b0;
      result_r <= 8'h00;
      int_n_d_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      int_n_d_r <= bus.int_n;
      if (go_any) begin
        op_rd_r <= sw_wdata[LFDLH_GO_READ];
      end
      if (state_r == LFDLH_CAPTURE) begin
        result_r <= bus.rdata;
      end
    end
  end

  // Software registers; status set wins over a clear.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tgt_addr_r <= 8'h00;
      tgt_wdata_r <= 8'h00;
      status_r <= 2'h0;
      mask_r <= 2'h0;
      sw_rdata_r <= 8'h00;
    end else begin
      status_r <= (status_r & ~st_clr) | {dev_int_ev, done_ev};
      sw_rdata_r <= sw_rd ? rd_mux : 8'h00;
      if (sw_wr && sw_addr == LFDLH_ADDR_ADDR && state_r == LFDLH_IDLE) begin
        tgt_addr_r <= sw_wdata;
      end
      if (sw_wr && sw_addr == LFDLH_WDATA_ADDR && state_r == LFDLH_IDLE) begin
        tgt_wdata_r <= sw_wdata;
      end
      if (sw_wr && sw_addr == LFDLH_MASK_ADDR) begin
        mask_r <= sw_wdata[1:0];
      end
    end
  end
endmodule : lfdl_host

// File: verilog/lfdl_if.sv
// Register port between the host controller and the link byte device.
// Assumes both ends share core_clk; read data follow a read by one cycle.
`timescale 1ns/1ps
interface lfdl_if;
  // Register access driven by the host.
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  // Answers driven by the device.
  logic [7:0] rdata;
  logic int_n;
  modport device (input addr, input wdata, input wr, input rd, output rdata, output int_n);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input int_n);
endinterface : lfdl_if

// File: verilog/lfdl_pkg.sv
// Constants shared by the legacy link byte port and its host controller.
// Assumes one clock domain and the framer logic running on that clock.
package lfdl_pkg;
  // Device register offsets, byte addresses on the device port.
  localparam logic [7:0] LFDL_RX_BYTE_ADDR = 8'hc0;
  localparam logic [7:0] LFDL_TX_BYTE_ADDR = 8'hc1;
  localparam logic [7:0] LFDL_MATCH_A_ADDR = 8'hc2;
  localparam logic [7:0] LFDL_MATCH_B_ADDR = 8'hc3;
  localparam logic [7:0] LFDL_STATUS_ADDR = 8'h20;
  localparam logic [7:0] LFDL_MASK_ADDR = 8'h21;
  localparam logic [7:0] LFDL_RX_CTRL2_ADDR = 8'h22;
  localparam logic [7:0] LFDL_TX_CTRL1_ADDR = 8'h23;
  localparam logic [7:0] LFDL_TX_CTRL2_ADDR = 8'h24;
  // Field positions.
  localparam int LFDL_ST_MATCH = 1;
  localparam int LFDL_ST_TX_EMPTY = 2;
  localparam int LFDL_ST_RX_FULL = 3;
  localparam int LFDL_RX_DESTUFF_BIT = 3;
  localparam int LFDL_TX_EXT_FRAME_BIT = 2;
  localparam int LFDL_TX_STUFF_BIT = 5;
  localparam int LFDL_TX_MF_LOAD_BIT = 6;
  // Reset values and run lengths.
  localparam logic [7:0] LFDL_BYTE_RESET = 8'h00;
  localparam logic [7:0] LFDL_STATUS_MASK = 8'h0e;
  localparam logic [2:0] LFDL_STUFF_RUN = 3'h5;
  localparam logic [2:0] LFDL_RUN_SAT = 3'h6;
  localparam logic [2:0] LFDL_LAST_BIT = 3'h7;
  // Host controller own register offsets.
  localparam logic [2:0] LFDLH_ADDR_ADDR = 3'h0;
  localparam logic [2:0] LFDLH_WDATA_ADDR = 3'h1;
  localparam logic [2:0] LFDLH_GO_ADDR = 3'h2;
  localparam logic [2:0] LFDLH_RESULT_ADDR = 3'h3;
  localparam logic [2:0] LFDLH_STATUS_ADDR = 3'h4;
  localparam logic [2:0] LFDLH_MASK_ADDR = 3'h5;
  localparam int LFDLH_ST_DONE = 0;
  localparam int LFDLH_ST_DEV_INT = 1;
  localparam int LFDLH_GO_WRITE = 0;
  localparam int LFDLH_GO_READ = 1;
  // Host access sequencer states.
  typedef enum logic [2:0] {
    LFDLH_IDLE = 3'b001,
    LFDLH_ISSUE = 3'b010,
    LFDLH_CAPTURE = 3'b100
  } lfdlh_state_type;
endpackage : lfdl_pkg
